// [dv/asma_mem_model.sv]
// Behavioural asynchronous static memory, 16 words deep.
// Assumes active-low strobes from the sequencer; it never sees pclk.
`timescale 1ns/1ps
module asma_mem_model (
  input wire asma_pkg::asma_mem_s mem,
  output logic [15:0] dq
);
  logic [15:0] store [16];
  logic [15:0] last = 16'h0000;
  wire rd_on = !mem.cs_n && !mem.oe_n;
  // Released bus shows the inverse of the last word, never a held value
  assign dq = rd_on ? store[mem.addr[3:0]] : ~last;
  always @(rd_on) if (rd_on) last = store[mem.addr[3:0]];
  // Latch on strobe rise: address and data must still be held
  always @(posedge mem.we_n) if (!mem.cs_n && !mem.dq_oe_n) begin
    store[mem.addr[3:0]] = mem.dq_out;
  end
endmodule

// [dv/tb_async_static_memory_access_modes.sv]
// Self-checking bench: APB register tasks plus memory access tasks.
// Assumes the memory model on the far side and a 10 MHz pclk.
`timescale 1ns/1ps
module tb_async_static_memory_access_modes;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic req_valid = 1'b0;
  asma_pkg::asma_req_s req = '0;
  logic req_ready;
  logic rsp_valid;
  logic [15:0] rsp_rdata;
  asma_pkg::asma_mem_s mem;
  logic [15:0] dq;
  logic mem_wait = 1'b0;
  int err_total = 0;
  int check_count = 0;
  logic [31:0] rd;
  logic err;
  int lat, oe_cnt, we_cnt, adv_cnt;

  always #50 pclk = ~pclk;

  asma_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem(mem),
    .mem_dq_in(dq), .mem_wait(mem_wait));
  asma_mem_model i_mem (.mem(mem), .dq(dq));

  // ==========================================
  // Access tasks
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rchk(input string nm, input logic [11:0] a,
                      input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, rd, exp);
  endtask

  task automatic mem_op(input logic w, input logic [3:0] a,
                        input logic [15:0] d);
    req_valid <= 1'b1;
    req <= '{write: w, addr: {22'h00_0000, a}, wdata: d};
    @(posedge pclk);
    while (req_ready !== 1'b1) @(posedge pclk);
    req_valid <= 1'b0;
    lat = 0;
    oe_cnt = 0;
    we_cnt = 0;
    adv_cnt = 0;
    while (rsp_valid !== 1'b1) begin
      @(negedge pclk);
      lat++;
      oe_cnt += int'(mem.oe_n === 1'b0);
      we_cnt += int'(mem.we_n === 1'b0);
      adv_cnt += int'(mem.adv_n === 1'b0);
    end
    @(posedge pclk);
  endtask

  // Latency: setup ta+1, data td+3 (read) or td+1 (write), one reply cycle
  task automatic acc(input string nm, input logic w, input logic [3:0] a,
                     input logic [15:0] d, input int ta, input int td,
                     input logic nor_kind);
    mem_op(w, a, d);
    chk({nm, " lat"}, lat, ta + td + (w ? 3 : 5));
    chk({nm, " strobe"}, w ? we_cnt : oe_cnt, w ? td : td + 3);
    chk({nm, " adv"}, adv_cnt, nor_kind ? ta + 1 : 0);
    if (!w) chk({nm, " data"}, {16'h0000, rsp_rdata}, {16'h0000, d});
  endtask

  always @(mem) if (presetn === 1'b1) chk("edge", pclk, 1'b1);

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================
  // Tests
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rchk("bank rst", asma_pkg::OFS_BANK, 32'h0000_0000);
    rchk("rtim rst", asma_pkg::OFS_RTIM, 32'h0000_FF0F);
    rchk("wtim rst", asma_pkg::OFS_WTIM, 32'h0000_FF0F);
    apb(1'b1, 12'h010, 32'hFFFF_FFFF);
    chk("unmapped err", err, 1'b1);
    rchk("unmapped rd", 12'h010, 32'h0000_0000);
    apb(1'b1, asma_pkg::OFS_RTIM, 32'hFFFF_FFFF);
    rchk("rtim mask", asma_pkg::OFS_RTIM, 32'h3000_FF0F);
    $display("test registers done");
    apb(1'b1, asma_pkg::OFS_BANK, 32'h0000_4001);
    apb(1'b1, asma_pkg::OFS_RTIM, 32'h0000_0102);
    apb(1'b1, asma_pkg::OFS_WTIM, 32'h0000_0301);
    rchk("stat A", asma_pkg::OFS_STAT, 32'h0000_0004);
    acc("A wr", 1'b1, 4'h5, 16'hBEEF, 1, 3, 1'b0);
    acc("A rd", 1'b0, 4'h5, 16'hBEEF, 2, 1, 1'b0);
    $display("test mode A done");
    apb(1'b1, asma_pkg::OFS_BANK, 32'h0000_0049);
    apb(1'b1, asma_pkg::OFS_RTIM, 32'h0000_0200);
    // Write timing must be ignored outside extended mode
    apb(1'b1, asma_pkg::OFS_WTIM, 32'h1000_0505);
    acc("2 wr", 1'b1, 4'hA, 16'h1234, 0, 2, 1'b1);
    acc("2 rd", 1'b0, 4'hA, 16'h1234, 0, 2, 1'b1);
    $display("test mode 2 done");
    apb(1'b1, asma_pkg::OFS_BANK, 32'h0000_4049);
    apb(1'b1, asma_pkg::OFS_RTIM, 32'h1000_010F);
    apb(1'b1, asma_pkg::OFS_WTIM, 32'h1000_0203);
    acc("B wr", 1'b1, 4'hF, 16'h5AA5, 3, 2, 1'b1);
    acc("B rd", 1'b0, 4'hF, 16'h5AA5, 15, 1, 1'b1);
    $display("test mode B done");
    apb(1'b1, asma_pkg::OFS_BANK, 32'h0000_0249);
    mem_wait <= 1'b1;
    acc("wait off", 1'b0, 4'hA, 16'h1234, 15, 1, 1'b1);
    apb(1'b1, asma_pkg::OFS_BANK, 32'h0000_8249);
    fork
      begin
        repeat (20) @(posedge pclk);
        mem_wait <= 1'b0;
      end
      mem_op(1'b0, 4'hA, 16'h1234);
    join
    // Unstalled this read takes 15 + 1 + 5 cycles
    chk("wait stall", lat > 21, 1'b1);
    chk("wait data", rsp_rdata, 16'h1234);
    $display("test wait done");
    conclude();
  end

  // Tests need a few hundred cycles; allow far more
  initial begin
    #2_000_000;
    err_total++;
    conclude();
  end
endmodule

// [logic/asma_ctrl.sv]
// Asynchronous static memory sequencer: modes A, 2 and B, APB registers.
// Requests come from on-chip logic on pclk; memory pins are asynchronous.
`timescale 1ns/1ps
module asma_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic req_valid,
  input wire asma_pkg::asma_req_s req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [asma_pkg::MEM_DATA_W-1:0] rsp_rdata,
  output asma_pkg::asma_mem_s mem,
  input wire logic [asma_pkg::MEM_DATA_W-1:0] mem_dq_in,
  input wire logic mem_wait
);
  // ==========================================================
  // APB slave
  logic [31:0] bank_reg, rtim_reg, wtim_reg, prdata_reg;
  logic pready_reg, pslverr_reg;
  logic [31:0] rd_mux;
  logic st_busy;
  wire setup_ph = psel && !penable && !pready_reg;
  wire wr_acc = psel && penable && pready_reg && pwrite;
  wire hit_bank = paddr == asma_pkg::OFS_BANK;
  wire hit_rtim = paddr == asma_pkg::OFS_RTIM;
  wire hit_wtim = paddr == asma_pkg::OFS_WTIM;
  wire hit_stat = paddr == asma_pkg::OFS_STAT;
  wire mapped = hit_bank || hit_rtim || hit_wtim || hit_stat;
  wire ext_mode = bank_reg[asma_pkg::EXT_BIT];
  wire nor_kind = bank_reg[asma_pkg::KIND_LSB+:2] == asma_pkg::KIND_NOR;
  wire [31:0] stat_word = {29'h0, ext_mode, nor_kind, st_busy};

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_bank) rd_mux = bank_reg;
    if (hit_rtim) rd_mux = rtim_reg;
    if (hit_wtim) rd_mux = wtim_reg;
    if (hit_stat) rd_mux = stat_word;
  end

  // One wait-free access phase; unmapped addresses answer with pslverr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= setup_ph;
      pslverr_reg <= setup_ph && !mapped;
      prdata_reg <= (setup_ph && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_reg <= asma_pkg::BANK_RST;
      rtim_reg <= asma_pkg::TIM_RST;
      wtim_reg <= asma_pkg::TIM_RST;
    end else if (wr_acc) begin
      if (hit_bank) bank_reg <= pwdata & asma_pkg::BANK_MASK;
      if (hit_rtim) rtim_reg <= pwdata & asma_pkg::TIM_MASK;
      if (hit_wtim) wtim_reg <= pwdata & asma_pkg::TIM_MASK;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // ==========================================================
  // Pin synchronisers
  logic [asma_pkg::MEM_DATA_W-1:0] dq_s1, dq_s2;
  logic wait_s1, wait_s2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_s1 <= 16'h0000;
      dq_s2 <= 16'h0000;
      wait_s1 <= 1'b0;
      wait_s2 <= 1'b0;
    end else begin
      dq_s1 <= mem_dq_in;
      dq_s2 <= dq_s1;
      wait_s1 <= mem_wait;
      wait_s2 <= wait_s1;
    end
  end

  // ==========================================================
  // Access sequencer
  asma_pkg::asma_state_e st_reg, st_next;
  asma_pkg::asma_mem_s mem_reg, mem_next;
  logic [8:0] cnt_reg, cnt_next;
  logic [31:0] lat_tim_reg, lat_tim_next;
  logic lat_wr_reg, lat_wr_next, lat_nor_reg, lat_nor_next;
  logic ready_reg, rsp_valid_reg;
  logic [asma_pkg::MEM_DATA_W-1:0] rdata_reg;

  wire take = (st_reg == asma_pkg::ST_IDLE) && req_valid && ready_reg;
  // Writes fall back to read timing outside extended mode
  wire [31:0] sel_tim =
    (req.write && ext_mode) ? wtim_reg : rtim_reg;
  wire [8:0] sel_setup = {5'h00, sel_tim[asma_pkg::SETUP_LSB+:4]};
  wire [8:0] lat_data_len = {1'b0, lat_tim_reg[asma_pkg::DATA_LEN_LSB+:8]};
  // Wait pin ignored unless its enable is set; polarity picks active level
  wire wait_act = bank_reg[asma_pkg::WAIT_EN_BIT] &&
                  (wait_s2 == bank_reg[asma_pkg::WAIT_POL_BIT]);
  wire stall = (st_reg == asma_pkg::ST_DATA) && wait_act;
  wire data_last = (st_reg == asma_pkg::ST_DATA) && !stall &&
                   cnt_reg == 9'h000;
  wire capture = data_last && !lat_wr_reg;
  assign st_busy = st_reg != asma_pkg::ST_IDLE;

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    lat_tim_next = lat_tim_reg;
    lat_wr_next = lat_wr_reg;
    lat_nor_next = lat_nor_reg;
    case (st_reg)
      asma_pkg::ST_IDLE: begin
        if (take) begin
          st_next = asma_pkg::ST_ADDR;
          lat_tim_next = sel_tim;
          lat_wr_next = req.write;
          lat_nor_next = nor_kind;
          cnt_next = sel_setup;
        end
      end
      asma_pkg::ST_ADDR: begin
        if (cnt_reg == 9'h000) begin
          st_next = asma_pkg::ST_DATA;
          cnt_next = lat_wr_reg ?
                     lat_data_len + asma_pkg::WR_DATA_EXTRA :
                     lat_data_len + asma_pkg::RD_DATA_EXTRA;
        end else begin
          cnt_next = cnt_reg - 9'h001;
        end
      end
      asma_pkg::ST_DATA: begin
        if (data_last) begin
          st_next = asma_pkg::ST_END;
        end else if (!stall) begin
          cnt_next = cnt_reg - 9'h001;
        end
      end
      asma_pkg::ST_END: begin
        st_next = asma_pkg::ST_IDLE;
      end
      default: begin
        st_next = asma_pkg::ST_IDLE;
      end
    endcase
  end

  // Pin values follow the next state so every pin is a flop output
  always_comb begin
    mem_next = mem_reg;
    if (take) begin
      mem_next.addr = req.addr;
      mem_next.dq_out = req.wdata;
    end
    mem_next.cs_n = 1'b1;
    mem_next.oe_n = 1'b1;
    mem_next.we_n = 1'b1;
    mem_next.adv_n = 1'b1;
    mem_next.dq_oe_n = 1'b1;
    case (st_next)
      asma_pkg::ST_ADDR: begin
        mem_next.cs_n = 1'b0;
        mem_next.adv_n = !lat_nor_next;
        mem_next.dq_oe_n = !lat_wr_next;
      end
      asma_pkg::ST_DATA: begin
        mem_next.cs_n = 1'b0;
        mem_next.oe_n = lat_wr_next;
        // Last write cycle has strobe high: hold time for address and data
        mem_next.we_n = !(lat_wr_next && cnt_next != 9'h000);
        mem_next.dq_oe_n = !lat_wr_next;
      end
      default: begin
        mem_next.cs_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= asma_pkg::ST_IDLE;
      cnt_reg <= 9'h000;
      lat_tim_reg <= asma_pkg::TIM_RST;
      lat_wr_reg <= 1'b0;
      lat_nor_reg <= 1'b0;
      mem_reg <= '{addr: '0, dq_out: '0, default: 1'b1};
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      lat_tim_reg <= lat_tim_next;
      lat_wr_reg <= lat_wr_next;
      lat_nor_reg <= lat_nor_next;
      mem_reg <= mem_next;
    end
  end

  // Refuse requests while the bank is disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_reg <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      ready_reg <= (st_next == asma_pkg::ST_IDLE) &&
                   bank_reg[asma_pkg::BANK_EN_BIT];
      rsp_valid_reg <= data_last;
      if (capture) rdata_reg <= dq_s2;
    end
  end

  assign req_ready = ready_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_rdata = rdata_reg;
  assign mem = mem_reg;

  // ==========================================================
  // Checks
  logic [8:0] ph_cyc_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ph_cyc_reg <= 9'h000;
    else if (st_next != st_reg) ph_cyc_reg <= 9'h000;
    else ph_cyc_reg <= ph_cyc_reg + 9'h001;
  end

  wire no_wait = !bank_reg[asma_pkg::WAIT_EN_BIT];
  wire [8:0] lat_setup_len = {5'h00, lat_tim_reg[asma_pkg::SETUP_LSB+:4]};
  sequence s_data_end;
    st_reg == asma_pkg::ST_DATA && st_next == asma_pkg::ST_END;
  endsequence
  sequence s_addr_end;
    st_reg == asma_pkg::ST_ADDR && st_next == asma_pkg::ST_DATA;
  endsequence

  AST_RD_DATA_LEN: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_data_end and (!lat_wr_reg && no_wait)
    |-> ph_cyc_reg == lat_data_len + 9'h002)
    else $error("read data phase length wrong");
  AST_WR_DATA_LEN: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_data_end and (lat_wr_reg && no_wait) |-> ph_cyc_reg == lat_data_len)
    else $error("write data phase length wrong");
  AST_RD_ADDR_LEN: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_addr_end and !lat_wr_reg |-> ph_cyc_reg == lat_setup_len)
    else $error("read address phase length wrong");
  AST_WR_TIM_SEL: assert property (
    @(posedge pclk) disable iff (!presetn)
    take && req.write && ext_mode |=> lat_tim_reg == $past(wtim_reg))
    else $error("extended write did not use write timing");
  AST_RD_TIM_FALLBACK: assert property (
    @(posedge pclk) disable iff (!presetn)
    take && !ext_mode |=> lat_tim_reg == $past(rtim_reg))
    else $error("write timing used outside extended mode");
  AST_OE_TOGGLE: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_reg == asma_pkg::ST_ADDR && !lat_wr_reg && cnt_reg == 9'h000
    |-> mem_reg.oe_n ##1 !mem_reg.oe_n)
    else $error("output enable did not toggle on read");
  AST_ADV_TOGGLE: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_reg == asma_pkg::ST_ADDR && lat_nor_reg && cnt_reg == 9'h000
    |-> !mem_reg.adv_n ##1 mem_reg.adv_n)
    else $error("address valid did not toggle");
  AST_ADV_MODE_A: assert property (
    @(posedge pclk) disable iff (!presetn)
    !lat_nor_reg |-> mem_reg.adv_n)
    else $error("address valid driven outside NOR kind");
  AST_SAMPLE_BEFORE_CS: assert property (
    @(posedge pclk) disable iff (!presetn)
    capture |-> !mem_reg.cs_n ##1 mem_reg.cs_n)
    else $error("read sample not before chip select release");
  AST_WR_HOLD: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(mem_reg.we_n) && st_reg == asma_pkg::ST_DATA
    |-> !mem_reg.cs_n && $stable(mem_reg.addr) && $stable(mem_reg.dq_out)
    ##1 mem_reg.cs_n)
    else $error("write hold cycle missing");
  AST_WAIT_IGNORED: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_reg == asma_pkg::ST_DATA && no_wait && cnt_reg != 9'h000
    |=> cnt_reg == $past(cnt_reg) - 9'h001)
    else $error("wait pin honoured while disabled");
endmodule

// [logic/asma_pkg.sv]
// Constants, types and register layout of the static memory sequencer.
// Assumes one clock (pclk, 10 MHz) shared by APB and memory port.
// Functional notes
// - Mode A toggles the output enable on reads; separate write timing only with extended mode set.
// - Modes 2 and B toggle address valid; separate write timing only with extended mode set.
// - Write timing is used only in extended mode, else writes use the read timing.
// - A read data phase lasts data phase length plus three clocks.
// - A write data phase lasts data phase length plus one clock.
// - A read address phase lasts address setup length plus one clock.
// - An extended-mode write address phase uses the write timing setup plus one clock.
// - Wait polarity counts only while bit 15 of bank control is set.
// - Memory outputs change only on rising pclk edges; the clock is not sent out.
// - Read data is sampled before chip select is released.
// - A write ends with one clock after the write strobe rises, address and data held.
package asma_pkg;
  localparam int MEM_ADDR_W = 26;
  localparam int MEM_DATA_W = 16;
  // APB byte offsets
  localparam logic [11:0] OFS_BANK = 12'h000;
  localparam logic [11:0] OFS_RTIM = 12'h004;
  localparam logic [11:0] OFS_WTIM = 12'h008;
  localparam logic [11:0] OFS_STAT = 12'h00C;
  // Bank control fields
  localparam int BANK_EN_BIT = 0;
  localparam int KIND_LSB = 2;
  localparam int WAIT_POL_BIT = 9;
  localparam int EXT_BIT = 14;
  localparam int WAIT_EN_BIT = 15;
  localparam logic [1:0] KIND_NOR = 2'h2;
  // Timing fields
  localparam int SETUP_LSB = 0;
  localparam int DATA_LEN_LSB = 8;
  localparam int ACCMODE_LSB = 28;
  // Writable bits; others read as zero
  localparam logic [31:0] BANK_MASK = 32'h0000_C37F;
  localparam logic [31:0] TIM_MASK = 32'h3000_FF0F;
  localparam logic [31:0] BANK_RST = 32'h0000_0000;
  localparam logic [31:0] TIM_RST = 32'h0000_FF0F;
  // Status bits
  localparam int STAT_BUSY = 0;
  localparam int STAT_NOR = 1;
  localparam int STAT_EXT = 2;
  // Extra cycles loaded into the phase counter
  localparam logic [8:0] RD_DATA_EXTRA = 9'h002;
  localparam logic [8:0] WR_DATA_EXTRA = 9'h000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b11,
    ST_END = 2'b10
  } asma_state_e;

  typedef struct packed {
    logic write;
    logic [MEM_ADDR_W-1:0] addr;
    logic [MEM_DATA_W-1:0] wdata;
  } asma_req_s;

  typedef struct packed {
    logic [MEM_ADDR_W-1:0] addr;
    logic [MEM_DATA_W-1:0] dq_out;
    logic dq_oe_n;
    logic cs_n;
    logic oe_n;
    logic we_n;
    logic adv_n;
  } asma_mem_s;
endpackage
